/* File: design/mc_watchdog_defines.svh */
// Constants of the multi-counter watchdog
`ifndef MC_WATCHDOG_DEFINES_SVH
`define MC_WATCHDOG_DEFINES_SVH

// Action codes of a 16-bit sub-counter
`define ACT_NONE 2'h0
`define ACT_IRQ 2'h1
`define ACT_RESET 2'h2
`define ACT_IRQ_THEN_RESET 2'h3

// Lock field write codes
`define LOCK_NOP 2'h0
`define LOCK_CLR_BIT0 2'h1
`define LOCK_CLR_BIT1 2'h2
`define LOCK_SET_BOTH 2'h3

// Reset values
`define COUNT16_RESET 16'h0000
`define COUNT32_RESET 32'h0000_0000
`define MATCH_RESET 16'h0000
`define LOCK_RESET 2'h0

// Unhandled interrupts already pending before the match that resets
`define UNHANDLED_LIMIT 2'h2

// Low-frequency ticks between lower match and upper increment
`define CASCADE_DELAY_TICKS 2

`endif

/* File: design/mc_watchdog_pkg.sv */
// Types of the multi-counter watchdog
`default_nettype none
package mc_watchdog_pkg;
  // Action taken by a 16-bit sub-counter on a match
  typedef logic [1:0] action_t;
  // Two-bit write lock field
  typedef logic [1:0] lock_t;
endpackage
`default_nettype wire

/* File: design/wdt_sub_counter.sv */
// 16-bit watchdog sub-counter with match and clear on match
`default_nettype none
`include "mc_watchdog_defines.svh"
module wdt_sub_counter #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Timing
  input wire logic tick,
  input wire logic enabled,
  input wire logic step,
  // Control
  input wire logic softReset,
  input wire logic clearOnMatch,
  input wire logic [WIDTH-1:0] matchVal,
  // Status
  output logic [WIDTH-1:0] count_q,
  output logic hit
);
  logic atMatch;
  logic wasAt_q;

  // ************************************************************
  // Match detection
  // ************************************************************
  // One event per arrival at the match value
  assign atMatch = (count_q == matchVal);
  assign hit = tick & enabled & atMatch & ~wasAt_q;

  always_ff @(posedge clock) begin
    if (srst) begin
      wasAt_q <= 1'b0;
    end else if (tick) begin
      wasAt_q <= enabled & atMatch;
    end
  end

  // ************************************************************
  // Counting
  // ************************************************************
  // Soft reset zeroes; clear on match wraps, else free-running
  always_ff @(posedge clock) begin
    if (srst) begin
      count_q <= '0;
    end else if (tick) begin
      if (softReset) begin
        count_q <= '0;
      end else if (enabled && step) begin
        if (atMatch && clearOnMatch) begin
          count_q <= '0;
        end else begin
          count_q <= count_q + WIDTH'(1);
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: design/multi_counter_dog.sv */
// Multi-counter watchdog with cascading, actions and reset cause flags
`default_nettype none
`include "mc_watchdog_defines.svh"
module multi_counter_dog
  import mc_watchdog_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  input wire logic coldReset,
  // Low-frequency clock pin and power state
  input wire logic lowFreqClockPin,
  input wire logic sleepMode,
  // Configuration write
  input wire logic cfgWrite,
  input wire action_t lowActionIn,
  input wire action_t midActionIn,
  input wire logic lowClearOnMatchIn,
  input wire logic midClearOnMatchIn,
  input wire logic cascadeLowMidIn,
  input wire logic cascadeMidHighIn,
  input wire logic toggleIrqEnableIn,
  input wire logic [4:0] toggleBitSelectIn,
  // Control write
  input wire logic ctlWrite,
  input wire logic [2:0] counterEnableIn,
  input wire logic [2:0] counterSoftResetIn,
  input wire lock_t writeLockIn,
  // Match write
  input wire logic matchWrite,
  input wire logic [15:0] lowMatchIn,
  input wire logic [15:0] midMatchIn,
  // Interrupt status clear and mask
  input wire logic irqClearWrite,
  input wire logic [2:0] irqClearIn,
  input wire logic maskWrite,
  input wire logic [2:0] irqMaskIn,
  // Reset cause
  input wire logic freeDogResetEvent,
  input wire logic [1:0] resetCauseClearIn,
  // Counter state
  output logic [15:0] lowCount,
  output logic [15:0] midCount,
  output logic [31:0] highCount,
  output logic [2:0] counterEnabled,
  output logic [2:0] counterSoftReset,
  output lock_t writeLock,
  // Interrupts
  output logic [2:0] counterIrqFlag,
  output logic [2:0] irqMask,
  output logic irqToCpu,
  output logic irqToWakeup,
  // Resets
  output logic deviceResetReq,
  output logic freeDogResetFlag,
  output logic multiDogResetFlag
);
  logic [2:0] lfSync_q;
  logic lfLevel_q;
  logic riseTick;
  logic fallTick;
  logic [2:0] enReq_q;
  logic [2:0] enHalf_q;
  action_t lowAction_q;
  action_t midAction_q;
  logic lowClear_q;
  logic midClear_q;
  logic cascadeLowMid_q;
  logic cascadeMidHigh_q;
  logic toggleIrqEnable_q;
  logic [4:0] toggleBitSelect_q;
  logic [15:0] lowMatch_q;
  logic [15:0] midMatch_q;
  logic [1:0] carryLowMid_q;
  logic [1:0] carryMidHigh_q;
  logic lowHit;
  logic midHit;
  logic midStep;
  logic highStep;
  logic [31:0] highNext;
  logic toggleHit;
  logic [1:0] unhandled_q [2];
  logic [1:0] hits;
  logic [1:0] matchReset;
  logic unlocked;
  logic irqLine;

  // ************************************************************
  // Low-frequency clock synchroniser and edge ticks
  // ************************************************************
  // Pin passes three flops; a level counts once flops two and three agree
  always_ff @(posedge clock) begin
    if (srst) begin
      lfSync_q <= 3'h0;
      lfLevel_q <= 1'b0;
    end else begin
      lfSync_q <= {lfSync_q[1:0], lowFreqClockPin};
      if (lfSync_q[1] == lfSync_q[2]) begin
        lfLevel_q <= lfSync_q[2];
      end
    end
  end

  // Ticks on agreed edges of the slow clock
  assign riseTick = (lfSync_q[1] == lfSync_q[2]) & lfSync_q[2] & ~lfLevel_q;
  assign fallTick = (lfSync_q[1] == lfSync_q[2]) & ~lfSync_q[2] & lfLevel_q;

  // ************************************************************
  // Write lock
  // ************************************************************
  assign unlocked = (writeLock == `LOCK_RESET);

  // Lock field accepted even while locked
  always_ff @(posedge clock) begin
    if (srst) begin
      writeLock <= `LOCK_RESET;
    end else if (ctlWrite) begin
      unique case (writeLockIn)
        `LOCK_CLR_BIT0: writeLock <= {writeLock[1], 1'b0};
        `LOCK_CLR_BIT1: writeLock <= {1'b0, writeLock[0]};
        `LOCK_SET_BOTH: writeLock <= 2'h3;
        `LOCK_NOP: writeLock <= writeLock;
      endcase
    end
  end

  // ************************************************************
  // Configuration and match registers
  // ************************************************************
  // Writes dropped while any lock bit is set
  always_ff @(posedge clock) begin
    if (srst) begin
      lowAction_q <= `ACT_NONE;
      midAction_q <= `ACT_NONE;
      lowClear_q <= 1'b0;
      midClear_q <= 1'b0;
      cascadeLowMid_q <= 1'b0;
      cascadeMidHigh_q <= 1'b0;
      toggleIrqEnable_q <= 1'b0;
      toggleBitSelect_q <= 5'h00;
    end else if (cfgWrite && unlocked) begin
      lowAction_q <= lowActionIn;
      midAction_q <= midActionIn;
      lowClear_q <= lowClearOnMatchIn;
      midClear_q <= midClearOnMatchIn;
      cascadeLowMid_q <= cascadeLowMidIn;
      cascadeMidHigh_q <= cascadeMidHighIn;
      toggleIrqEnable_q <= toggleIrqEnableIn;
      toggleBitSelect_q <= toggleBitSelectIn;
    end
  end

  // Prescale from low match, period from middle match
  always_ff @(posedge clock) begin
    if (srst) begin
      lowMatch_q <= `MATCH_RESET;
      midMatch_q <= `MATCH_RESET;
    end else if (matchWrite && unlocked) begin
      lowMatch_q <= lowMatchIn;
      midMatch_q <= midMatchIn;
    end
  end

  // ************************************************************
  // Enable with 1.5 slow cycle latency
  // ************************************************************
  // Request sampled on a rise, takes effect on the following fall
  always_ff @(posedge clock) begin
    if (srst) begin
      enReq_q <= 3'h0;
      enHalf_q <= 3'h0;
      counterEnabled <= 3'h0;
    end else begin
      if (ctlWrite && unlocked) begin
        enReq_q <= counterEnableIn;
      end
      if (riseTick) begin
        enHalf_q <= enReq_q;
      end
      if (fallTick) begin
        counterEnabled <= enHalf_q;
      end
    end
  end

  // ************************************************************
  // Soft reset bits
  // ************************************************************
  // Cleared by hardware on the tick that zeroes the counter
  always_ff @(posedge clock) begin
    if (srst) begin
      counterSoftReset <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (ctlWrite && unlocked && counterSoftResetIn[i]) begin
          counterSoftReset[i] <= 1'b1;
        end else if (riseTick) begin
          counterSoftReset[i] <= 1'b0;
        end
      end
    end
  end

  // ************************************************************
  // Cascade carries
  // ************************************************************
  // Two-tick pipes; one event per match, none the tick after
  always_ff @(posedge clock) begin
    if (srst) begin
      carryLowMid_q <= 2'h0;
      carryMidHigh_q <= 2'h0;
    end else if (riseTick) begin
      carryLowMid_q <= {carryLowMid_q[0], lowHit};
      carryMidHigh_q <= {carryMidHigh_q[0], midHit};
    end
  end

  // Upper counter steps only on carry when cascaded
  assign midStep = cascadeLowMid_q ? carryLowMid_q[1] : 1'b1;
  assign highStep = cascadeMidHigh_q ? carryMidHigh_q[1] : 1'b1;

  // ************************************************************
  // 16-bit sub-counters
  // ************************************************************
  // Pipe is not flushed by soft reset, so upper may end at one
  wdt_sub_counter #(.WIDTH(16)) lowCounter (
    .clock(clock),
    .srst(srst),
    .tick(riseTick),
    .enabled(counterEnabled[0]),
    .step(1'b1),
    .softReset(counterSoftReset[0]),
    .clearOnMatch(lowClear_q),
    .matchVal(lowMatch_q),
    .count_q(lowCount),
    .hit(lowHit)
  );

  wdt_sub_counter #(.WIDTH(16)) midCounter (
    .clock(clock),
    .srst(srst),
    .tick(riseTick),
    .enabled(counterEnabled[1]),
    .step(midStep),
    .softReset(counterSoftReset[1]),
    .clearOnMatch(midClear_q),
    .matchVal(midMatch_q),
    .count_q(midCount),
    .hit(midHit)
  );

  // ************************************************************
  // 32-bit counter with bit toggle event
  // ************************************************************
  assign highNext = highCount + 32'h0000_0001;
  assign toggleHit = riseTick & counterEnabled[2] & highStep & ~counterSoftReset[2]
    & toggleIrqEnable_q & (highCount[toggleBitSelect_q] ^ highNext[toggleBitSelect_q]);

  always_ff @(posedge clock) begin
    if (srst) begin
      highCount <= `COUNT32_RESET;
    end else if (riseTick) begin
      if (counterSoftReset[2]) begin
        highCount <= `COUNT32_RESET;
      end else if (counterEnabled[2] && highStep) begin
        highCount <= highNext;
      end
    end
  end

  // ************************************************************
  // Match actions
  // ************************************************************
  assign hits = {midHit, lowHit};

  // Reset on match, or on third match with the flag still pending
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      matchReset[i] = hits[i] & (((i == 0 ? lowAction_q : midAction_q) == `ACT_RESET)
        | (((i == 0 ? lowAction_q : midAction_q) == `ACT_IRQ_THEN_RESET)
        & counterIrqFlag[i] & (unhandled_q[i] == `UNHANDLED_LIMIT)));
    end
  end

  // Count restarts once the flag is cleared; the match raising the flag counts first
  always_ff @(posedge clock) begin
    if (srst) begin
      unhandled_q[0] <= 2'h0;
      unhandled_q[1] <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!counterIrqFlag[i] && !hits[i]) begin
          unhandled_q[i] <= 2'h0;
        end else if (hits[i] && unhandled_q[i] != `UNHANDLED_LIMIT) begin
          unhandled_q[i] <= unhandled_q[i] + 2'h1;
        end
      end
    end
  end

  // One-cycle device reset request
  always_ff @(posedge clock) begin
    if (srst) begin
      deviceResetReq <= 1'b0;
    end else begin
      deviceResetReq <= |matchReset;
    end
  end

  // ************************************************************
  // Interrupt flags, mask and routing
  // ************************************************************
  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      counterIrqFlag <= 3'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (hits[i] && ((i == 0 ? lowAction_q : midAction_q) inside
            {`ACT_IRQ, `ACT_IRQ_THEN_RESET})) begin
          counterIrqFlag[i] <= 1'b1;
        end else if (irqClearWrite && irqClearIn[i]) begin
          counterIrqFlag[i] <= 1'b0;
        end
      end
      if (toggleHit) begin
        counterIrqFlag[2] <= 1'b1;
      end else if (irqClearWrite && irqClearIn[2]) begin
        counterIrqFlag[2] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      irqMask <= 3'h0;
    end else if (maskWrite) begin
      irqMask <= irqMaskIn;
    end
  end

  // Single merged line, steered by power state
  assign irqLine = |(counterIrqFlag & irqMask);
  assign irqToCpu = irqLine & ~sleepMode;
  assign irqToWakeup = irqLine & sleepMode;

  // ************************************************************
  // Reset cause flags
  // ************************************************************
  // Survive the block reset; only cold reset or software clears
  always_ff @(posedge clock) begin
    if (coldReset) begin
      freeDogResetFlag <= 1'b0;
      multiDogResetFlag <= 1'b0;
    end else begin
      if (freeDogResetEvent) begin
        freeDogResetFlag <= 1'b1;
      end else if (resetCauseClearIn[0]) begin
        freeDogResetFlag <= 1'b0;
      end
      if (|matchReset) begin
        multiDogResetFlag <= 1'b1;
      end else if (resetCauseClearIn[1]) begin
        multiDogResetFlag <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/mc_watchdog_monitor.sv */
// Port checker of the multi-counter watchdog
`default_nettype none
module mc_watchdog_monitor
  import mc_watchdog_pkg::*;
(
  // Clock and resets
  input wire logic clock,
  input wire logic srst,
  input wire logic coldReset,
  // Inputs watched
  input wire logic sleepMode,
  input wire logic ctlWrite,
  input wire logic [2:0] counterSoftResetIn,
  input wire lock_t writeLockIn,
  input wire logic irqClearWrite,
  input wire logic [2:0] irqClearIn,
  input wire logic maskWrite,
  input wire logic [2:0] irqMaskIn,
  input wire logic [1:0] resetCauseClearIn,
  // Outputs watched
  input wire logic [2:0] counterSoftReset,
  input wire lock_t writeLock,
  input wire logic [2:0] counterIrqFlag,
  input wire logic [2:0] irqMask,
  input wire logic irqToCpu,
  input wire logic irqToWakeup,
  input wire logic deviceResetReq,
  input wire logic multiDogResetFlag
);
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  cpu_line_a: assert property (irqToCpu == (|(counterIrqFlag & irqMask) && !sleepMode))
    else $error("cpu interrupt line wrong");
  wake_line_a: assert property (irqToWakeup == (|(counterIrqFlag & irqMask) && sleepMode))
    else $error("wakeup interrupt line wrong");
  reset_pulse_a: assert property (deviceResetReq |=> !deviceResetReq)
    else $error("device reset request too long");
  cause_set_a: assert property (deviceResetReq |-> multiDogResetFlag)
    else $error("reset cause not recorded");
  cause_sticky_a: assert property ($fell(multiDogResetFlag) |-> $past(resetCauseClearIn[1] || coldReset))
    else $error("reset cause lost");
  lock_set_a: assert property (ctlWrite && writeLockIn == 2'h3 |=> writeLock == 2'h3)
    else $error("lock not set");
  lock_clear_a: assert property (ctlWrite && writeLockIn == 2'h1 |=> writeLock == {$past(writeLock[1]), 1'b0})
    else $error("lock bit zero not cleared");
  soft_guard_a: assert property ($rose(counterSoftReset[1]) |-> $past(ctlWrite && counterSoftResetIn[1] && writeLock == 2'h0))
    else $error("soft reset set while locked");
  flag_clear_a: assert property ($fell(counterIrqFlag[0]) && !$past(srst) |-> $past(irqClearWrite && irqClearIn[0]))
    else $error("flag dropped without clear");
  mask_load_a: assert property (maskWrite |=> irqMask == $past(irqMaskIn))
    else $error("mask not loaded");

  // Main scenarios reached
  cover property (deviceResetReq);
  cover property (irqToCpu);
  cover property (irqToWakeup);
  cover property (writeLock == 2'h3);
endmodule
`default_nettype wire

/* File: bench/tb_multi_counter_dog.sv */
// Self-checking bench of the multi-counter watchdog
`default_nettype none
`include "mc_watchdog_defines.svh"
module tb_multi_counter_dog;
  timeunit 1ns;
  timeprecision 1ps;
  // ********************
  // Stimulus and observed signals
  // ********************
  logic clock = 1'b0, srst = 1'b1, coldReset = 1'b1, lowFreqClockPin = 1'b0, sleepMode = 1'b0;
  logic cfgWrite = 1'b0, lowClr = 1'b0, midClr = 1'b0, cascLm = 1'b0, cascMh = 1'b0;
  logic togEn = 1'b0, ctlWrite = 1'b0, matchWrite = 1'b0, irqClearWrite = 1'b0;
  logic maskWrite = 1'b0, freeEv = 1'b0;
  logic [1:0] lowAct = '0, midAct = '0, lockIn = '0, causeClr = '0, writeLock;
  logic [4:0] togSel = '0;
  logic [2:0] enIn = '0, srIn = '0, irqClearIn = '0, irqMaskIn = '0;
  logic [15:0] lowMatch = '0, midMatch = '0, lowCount, midCount;
  logic [31:0] highCount;
  logic [2:0] enabled, softRst, irqFlag, irqMask;
  logic irqToCpu, irqToWakeup, devRst, freeFlag, multiFlag;
  int error_cnt = 0, num_checks = 0;

  // Clock and slow clock pin, period eight clocks
  always #5 clock = ~clock;
  always begin
    repeat (4) @(negedge clock);
    lowFreqClockPin = ~lowFreqClockPin;
  end

  multi_counter_dog u_multi_counter_dog (.clock(clock), .srst(srst), .coldReset(coldReset),
    .lowFreqClockPin(lowFreqClockPin), .sleepMode(sleepMode), .cfgWrite(cfgWrite),
    .lowActionIn(lowAct), .midActionIn(midAct), .lowClearOnMatchIn(lowClr),
    .midClearOnMatchIn(midClr), .cascadeLowMidIn(cascLm), .cascadeMidHighIn(cascMh),
    .toggleIrqEnableIn(togEn), .toggleBitSelectIn(togSel), .ctlWrite(ctlWrite),
    .counterEnableIn(enIn), .counterSoftResetIn(srIn), .writeLockIn(lockIn),
    .matchWrite(matchWrite), .lowMatchIn(lowMatch), .midMatchIn(midMatch),
    .irqClearWrite(irqClearWrite), .irqClearIn(irqClearIn), .maskWrite(maskWrite),
    .irqMaskIn(irqMaskIn), .freeDogResetEvent(freeEv), .resetCauseClearIn(causeClr),
    .lowCount(lowCount), .midCount(midCount), .highCount(highCount),
    .counterEnabled(enabled), .counterSoftReset(softRst), .writeLock(writeLock),
    .counterIrqFlag(irqFlag), .irqMask(irqMask), .irqToCpu(irqToCpu),
    .irqToWakeup(irqToWakeup), .deviceResetReq(devRst), .freeDogResetFlag(freeFlag),
    .multiDogResetFlag(multiFlag));

  // ********************
  // Shared tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: %s got %0h", $time, msg, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Configuration write, one strobe cycle
  task automatic cfg(input logic [1:0] la, input logic [1:0] ma, input logic [4:0] bits);
    @(negedge clock);
    lowAct = la;
    midAct = ma;
    {lowClr, midClr, cascLm, cascMh, togEn} = bits;
    cfgWrite = 1'b1;
    @(negedge clock);
    cfgWrite = 1'b0;
  endtask

  task automatic ctl(input logic [2:0] en, input logic [2:0] sr, input logic [1:0] lk);
    @(negedge clock);
    enIn = en;
    srIn = sr;
    lockIn = lk;
    ctlWrite = 1'b1;
    @(negedge clock);
    ctlWrite = 1'b0;
  endtask

  task automatic match(input logic [15:0] lo, input logic [15:0] mi);
    @(negedge clock);
    lowMatch = lo;
    midMatch = mi;
    matchWrite = 1'b1;
    @(negedge clock);
    matchWrite = 1'b0;
  endtask

  task automatic irqClr(input logic [2:0] v);
    @(negedge clock);
    irqClearIn = v;
    irqClearWrite = 1'b1;
    @(negedge clock);
    irqClearWrite = 1'b0;
  endtask

  task automatic mask(input logic [2:0] v);
    @(negedge clock);
    irqMaskIn = v;
    maskWrite = 1'b1;
    @(negedge clock);
    maskWrite = 1'b0;
  endtask

  // Feed from the main flow, set action and match, clear flags, enable, await status
  task automatic arm(input logic [1:0] act, input logic [15:0] lo);
    int n;
    ctl(3'b000, 3'b111, `LOCK_NOP);
    cfg(act, `ACT_NONE, 5'b10000);
    match(lo, 16'h0002);
    repeat (24) @(negedge clock);
    irqClr(3'b111);
    ctl(3'b001, 3'b000, `LOCK_NOP);
    for (n = 0; n < 40 && enabled[0] !== 1'b1; n++) @(negedge clock);
  endtask

  // ********************
  // Scenarios
  // ********************
  task automatic testIrq();
    int n;
    match(16'h0003, 16'h0005);
    cfg(`ACT_IRQ, `ACT_NONE, 5'b10000);
    ctl(3'b001, 3'b000, `LOCK_NOP);
    chk(enabled[0], 1'b0, "enable too early");
    for (n = 0; n < 40 && enabled[0] !== 1'b1; n++) @(negedge clock);
    chk(enabled[0], 1'b1, "enabled status");
    for (n = 0; n < 100 && irqFlag[0] !== 1'b1; n++) @(negedge clock);
    chk(irqFlag, 3'b001, "low flag");
    chk(lowCount, 16'h0000, "clear on match");
    chk(irqToCpu, 1'b0, "masked line");
    mask(3'b001);
    chk(irqMask, 3'b001, "mask loaded");
    chk(irqToCpu, 1'b1, "cpu line");
    sleepMode = 1'b1;
    @(negedge clock);
    chk({irqToCpu, irqToWakeup}, 2'b01, "sleep routing");
    sleepMode = 1'b0;
    irqClr(3'b001);
    chk(irqFlag[0], 1'b0, "write one clears");
  endtask

  task automatic testCascade();
    logic [15:0] prev;
    int steps;
    int n;
    match(16'h0003, 16'h0002);
    cfg(`ACT_NONE, `ACT_NONE, 5'b11100);
    ctl(3'b011, 3'b011, `LOCK_NOP);
    repeat (40) @(negedge clock);
    prev = midCount;
    steps = 0;
    repeat (24) begin
      repeat (8) @(negedge clock);
      // Upper counter only read while the prescaler is nonzero
      if (lowCount !== 16'h0000) begin
        if (midCount !== prev) begin
          steps++;
          chk(lowCount, 16'h0002, "upper step two ticks late");
        end
        chk(midCount <= 16'h0002, 1'b1, "upper period");
        prev = midCount;
      end
    end
    chk(steps, 6, "one step per prescale");
    // Reset both while the prescaler sits at its match value
    for (n = 0; n < 40 && lowCount !== 16'h0003; n++) @(negedge clock);
    ctl(3'b011, 3'b011, `LOCK_NOP);
    repeat (24) @(negedge clock);
    chk(midCount, 16'h0001, "upper left at one");
    // Second upper reset some slow cycles later
    ctl(3'b011, 3'b010, `LOCK_NOP);
    repeat (8) @(negedge clock);
    chk(midCount, 16'h0000, "second upper reset");
  endtask

  task automatic testReset();
    int n;
    int hits;
    logic [15:0] prev;
    ctl(3'b000, 3'b111, `LOCK_NOP);
    chk(softRst, 3'b111, "soft reset pending");
    repeat (12) @(negedge clock);
    chk({softRst, lowCount}, 19'h0, "soft reset done");
    arm(`ACT_RESET, 16'h0002);
    for (n = 0; n < 200 && devRst !== 1'b1; n++) @(negedge clock);
    chk(devRst, 1'b1, "reset on match");
    @(negedge clock);
    chk({devRst, multiFlag}, 2'b01, "pulse and cause");
    arm(`ACT_IRQ_THEN_RESET, 16'h0001);
    hits = 0;
    for (n = 0; n < 300 && devRst !== 1'b1; n++) begin
      prev = lowCount;
      @(negedge clock);
      if (prev == 16'h0001 && lowCount == 16'h0000) hits++;
    end
    chk(hits, 3, "third unhandled match");
    srst = 1'b1;
    freeEv = 1'b1;
    @(negedge clock);
    srst = 1'b0;
    freeEv = 1'b0;
    chk({freeFlag, multiFlag}, 2'b11, "cause survives reset");
    causeClr = 2'b10;
    @(negedge clock);
    causeClr = 2'b00;
    chk({freeFlag, multiFlag}, 2'b10, "cause cleared");
    coldReset = 1'b1;
    @(negedge clock);
    coldReset = 1'b0;
    chk(freeFlag, 1'b0, "cold reset clears");
  endtask

  task automatic testToggleLock();
    int n;
    cfg(`ACT_NONE, `ACT_NONE, 5'b00001);
    @(negedge clock);
    togSel = 5'h01;
    cfg(`ACT_NONE, `ACT_NONE, 5'b00001);
    ctl(3'b100, 3'b000, `LOCK_NOP);
    for (n = 0; n < 200 && irqFlag[2] !== 1'b1; n++) @(negedge clock);
    chk(highCount, 32'h0000_0002, "toggle of bit one");
    mask(3'b100);
    chk(irqToCpu, 1'b1, "merged line");
    ctl(3'b100, 3'b000, `LOCK_SET_BOTH);
    chk(writeLock, 2'h3, "locked");
    ctl(3'b100, 3'b010, `LOCK_NOP);
    chk(softRst, 3'b000, "write blocked");
    ctl(3'b100, 3'b000, `LOCK_CLR_BIT0);
    chk(writeLock, 2'h2, "bit zero cleared");
    ctl(3'b100, 3'b000, `LOCK_CLR_BIT1);
    ctl(3'b100, 3'b010, `LOCK_NOP);
    chk({writeLock, softRst}, 5'b00010, "unlocked write");
  endtask

  // ********************
  // Main sequence and watchdog
  // ********************
  initial begin
    repeat (4) @(negedge clock);
    srst = 1'b0;
    coldReset = 1'b0;
    testIrq();
    testCascade();
    testReset();
    testToggleLock();
    conclude();
  end

  initial begin
    repeat (6000) @(posedge clock);
    error_cnt++;
    conclude();
  end
endmodule

bind multi_counter_dog mc_watchdog_monitor u_mc_watchdog_monitor (.clock(clock), .srst(srst),
  .coldReset(coldReset), .sleepMode(sleepMode), .ctlWrite(ctlWrite),
  .counterSoftResetIn(counterSoftResetIn), .writeLockIn(writeLockIn),
  .irqClearWrite(irqClearWrite), .irqClearIn(irqClearIn), .maskWrite(maskWrite),
  .irqMaskIn(irqMaskIn), .resetCauseClearIn(resetCauseClearIn),
  .counterSoftReset(counterSoftReset), .writeLock(writeLock), .counterIrqFlag(counterIrqFlag),
  .irqMask(irqMask), .irqToCpu(irqToCpu), .irqToWakeup(irqToWakeup),
  .deviceResetReq(deviceResetReq), .multiDogResetFlag(multiDogResetFlag));
`default_nettype wire
